// [src/sct_consts.svh]
// Offsets, field layouts, reset values and timing counts of the cycle timer
`ifndef SCT_CONSTS_SVH
`define SCT_CONSTS_SVH
// Time base
`define SCT_MAINS_HZ 60
`define SCT_TICK_HZ 10
`define SCT_MAINS_PER_TICK (`SCT_MAINS_HZ / `SCT_TICK_HZ)
`define SCT_TPS 10
// Table sizes
`define SCT_MAX_CYCLE_S 255
`define SCT_N_IVL 24
`define SCT_N_OFS 5
`define SCT_SIG_W 16
// Register byte offsets
`define SCT_A_CTRL 8'h00
`define SCT_A_KEY 8'h04
`define SCT_A_SEL 8'h08
`define SCT_A_DATA 8'h0c
`define SCT_A_STAT 8'h10
`define SCT_A_ADV 8'h14
`define SCT_A_TIME 8'h18
// Control register fields
`define SCT_CTRL_MANUAL 0
`define SCT_CTRL_SHORTWAY 1
// Keypad codes, values arbitrary
`define SCT_CODE_ACCESS 16'h5a3c
`define SCT_CODE_BYP_OFF 16'h0f0f
`define SCT_CODE_BYP_ON 16'hf0f0
// Reset values
`define SCT_RST_IVL 5'h17
`define SCT_RST_REQ 1'b1
`endif

// [src/sct_pkg.sv]
// Types shared by the cycle timer
package sct_pkg;
  typedef enum logic [2:0] {
    SCT_TBL_CYC = 3'h0,
    SCT_TBL_OFS = 3'h1,
    SCT_TBL_IVL = 3'h2,
    SCT_TBL_PLAN = 3'h3,
    SCT_TBL_DWELL = 3'h4
  } sct_tbl_t;

  // Selection register layout
  typedef struct packed {
    sct_tbl_t tbl;
    logic [4:0] ivl;
    logic [2:0] ofs;
    logic [1:0] split;
    logic [2:0] dial;
  } sct_sel_t;

  // One stored interval setting
  typedef struct packed {
    logic excl;
    logic hold;
    logic unit_s;
    logic [9:0] val;
  } sct_ivl_t;

  typedef struct packed {
    logic [2:0] mdiv;
    logic mprev;
    logic [3:0] ten;
    logic [3:0] rten;
    logic [7:0] rsec;
    logic [7:0] lsec;
    logic [4:0] ivl;
    logic [13:0] rem;
    logic frz;
    logic [7:0] dwc;
    logic [15:0] sig;
    logic manual;
    logic shortway;
    sct_sel_t sel;
    logic req;
    logic unl;
    logic refused;
    logic [31:0] rdata;
    logic [2:0] dial;
    logic [1:0] split;
    logic [2:0] ofs;
    logic [2:0] plan;
  } sct_state_t;
endpackage

// [src/sct_signal_cycle_timer.sv]
// Fixed-time signal cycle timer with offset correction and keypad access control
`timescale 1ns/1ps
`include "sct_consts.svh"

module sct_signal_cycle_timer (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Mains reference and coordinator selects
  input wire logic i_mains,
  input wire logic [2:0] i_dial_sel,
  input wire logic [1:0] i_split_sel,
  input wire logic [2:0] i_ofs_sel,
  input wire logic [2:0] i_plan_sel,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Signal outputs and indicators
  output logic [15:0] o_signals,
  output logic [2:0] o_act_dial,
  output logic [2:0] o_act_ofs,
  output logic [4:0] o_act_ivl,
  output logic o_correcting
);

  sct_pkg::sct_state_t st_ff;
  sct_pkg::sct_state_t nxt_st;

  // Timing tables
  logic [7:0] cyc_mem [0:7];
  logic [7:0] ofs_mem [0:63];
  logic [7:0] dwl_mem [0:7];
  sct_pkg::sct_ivl_t ivl_mem [0:1023];
  logic [15:0] plan_mem [0:255];

  logic tick;
  logic rise;
  logic [7:0] cur_c;
  logic [7:0] half_c;
  logic [7:0] lim;
  logic [7:0] ahead;
  logic [9:0] diff;
  sct_pkg::sct_ivl_t ent;
  sct_pkg::sct_ivl_t nx_ent;
  logic [4:0] nx_ivl;
  logic [2:0] nx_dial;
  logic [1:0] nx_split;
  logic [2:0] nx_ofs;
  logic [2:0] nx_plan;
  logic adv_req;
  logic step;
  logic wr_ok;
  logic dat_ok;
  logic dat_wr;

  // Seconds counter step with wrap at cycle length
  function automatic logic [7:0] sec_add(input logic [7:0] a, input logic [7:0] c);
    logic [8:0] s;
    s = {1'b0, a} + 9'h001;
    sec_add = (s >= {1'b0, c}) ? 8'h00 : s[7:0];
  endfunction

  // Interval duration in ticks
  function automatic logic [13:0] ld_time(input sct_pkg::sct_ivl_t e);
    ld_time = e.unit_s ? 14'(e.val) * 14'(`SCT_TPS) : 14'(e.val);
  endfunction

  // Mains edge and tenth-second tick
  assign rise = i_mains && !st_ff.mprev;
  assign tick = rise && (st_ff.mdiv == 3'(`SCT_MAINS_PER_TICK - 1));

  // Active settings of the running cycle
  assign cur_c = cyc_mem[st_ff.dial];
  assign half_c = cur_c >> 1;
  assign lim = (dwl_mem[st_ff.dial] < half_c) ? dwl_mem[st_ff.dial] : half_c;
  assign ent = ivl_mem[{st_ff.dial, st_ff.split, st_ff.ivl}];

  // Lead of local cycle over reference, modulo cycle length
  assign diff = 10'(st_ff.lsec) + 10'(ofs_mem[{st_ff.dial, st_ff.ofs}]) + 10'(cur_c) - 10'(st_ff.rsec);
  assign ahead = (cur_c == 8'h00) ? 8'h00 : 8'(diff % 10'(cur_c));

  // Next interval; coordinator selects are taken at cycle start
  assign nx_ivl = (st_ff.ivl == 5'(`SCT_N_IVL - 1)) ? 5'h00 : st_ff.ivl + 5'h01;
  assign nx_dial = (nx_ivl == 5'h00) ? i_dial_sel : st_ff.dial;
  assign nx_split = (nx_ivl == 5'h00) ? i_split_sel : st_ff.split;
  assign nx_ofs = (nx_ivl != 5'h00) ? st_ff.ofs : (i_ofs_sel < 3'(`SCT_N_OFS)) ? i_ofs_sel : 3'h0;
  assign nx_plan = (nx_ivl == 5'h00) ? i_plan_sel : st_ff.plan;
  assign nx_ent = ivl_mem[{nx_dial, nx_split, nx_ivl}];

  // Interval change: timeout in auto mode, accepted advance in manual mode
  // A hold that starts on the tick that empties the interval must still hold,
  // so an automatic step waits while local timing is frozen
  assign adv_req = i_wr && (i_addr == `SCT_A_ADV);
  assign step = st_ff.manual ? (adv_req && (!ent.hold || st_ff.rem == 14'h0000))
                             : (st_ff.rem == 14'h0000 && !st_ff.frz);

  // Timing entry permission and index check
  assign wr_ok = !st_ff.req || st_ff.unl;
  assign dat_ok = wr_ok && (st_ff.sel.tbl <= sct_pkg::SCT_TBL_DWELL)
    && !(st_ff.sel.tbl == sct_pkg::SCT_TBL_OFS && st_ff.sel.ofs >= 3'(`SCT_N_OFS))
    && !(st_ff.sel.tbl == sct_pkg::SCT_TBL_IVL && st_ff.sel.ivl >= 5'(`SCT_N_IVL))
    && !(st_ff.sel.tbl == sct_pkg::SCT_TBL_PLAN && st_ff.sel.ivl >= 5'(`SCT_N_IVL));
  assign dat_wr = i_wr && (i_addr == `SCT_A_DATA) && dat_ok;

  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = 32'h0000_0000;
    nxt_st.mprev = i_mains;
    if (rise) begin
      nxt_st.mdiv = tick ? 3'h0 : st_ff.mdiv + 3'h1;
    end
    if (tick) begin
      // Reference cycle position
      if (st_ff.rten == 4'(`SCT_TPS - 1)) begin
        nxt_st.rten = 4'h0;
        nxt_st.rsec = sec_add(st_ff.rsec, cur_c);
      end else begin
        nxt_st.rten = st_ff.rten + 4'h1;
      end
      // Local interval and cycle timing
      nxt_st.ten = (st_ff.ten == 4'(`SCT_TPS - 1)) ? 4'h0 : st_ff.ten + 4'h1;
      if (!st_ff.frz && st_ff.rem != 14'h0000) begin
        nxt_st.rem = st_ff.rem - 14'h0001;
      end
      if (st_ff.ten == 4'(`SCT_TPS - 1)) begin
        if (!st_ff.frz) begin
          nxt_st.lsec = sec_add(st_ff.lsec, cur_c);
        end
        nxt_st.frz = 1'b0;
        if (!st_ff.manual && ahead != 8'h00) begin
          if (!st_ff.shortway) begin
            // Dwell at cycle start until back in step, at most lim seconds per cycle
            if (st_ff.ivl == 5'h00 && st_ff.dwc < lim) begin
              nxt_st.frz = 1'b1;
              nxt_st.dwc = st_ff.dwc + 8'h01;
            end
          end else if (!ent.excl) begin
            if (ahead <= half_c) begin
              nxt_st.frz = 1'b1;
            end else if (!st_ff.frz && st_ff.rem > 14'(`SCT_TPS)) begin
              nxt_st.rem = st_ff.rem - 14'(`SCT_TPS + 1);
              nxt_st.lsec = sec_add(sec_add(st_ff.lsec, cur_c), cur_c);
            end
          end
        end
      end
    end
    // Interval change loads outputs in one edge
    if (step) begin
      nxt_st.ivl = nx_ivl;
      nxt_st.rem = ld_time(nx_ent);
      nxt_st.sig = plan_mem[{nx_plan, nx_ivl}];
      nxt_st.frz = 1'b0;
      nxt_st.dial = nx_dial;
      nxt_st.split = nx_split;
      nxt_st.ofs = nx_ofs;
      nxt_st.plan = nx_plan;
      if (nx_ivl == 5'h00) begin
        nxt_st.lsec = 8'h00;
        nxt_st.dwc = 8'h00;
      end
    end
    // Register writes
    if (i_wr) begin
      if (i_addr == `SCT_A_CTRL) begin
        nxt_st.manual = i_wdata[`SCT_CTRL_MANUAL];
        nxt_st.shortway = i_wdata[`SCT_CTRL_SHORTWAY];
      end else if (i_addr == `SCT_A_KEY) begin
        if (i_wdata[15:0] == `SCT_CODE_ACCESS) begin
          nxt_st.unl = 1'b1;
        end else if (i_wdata[15:0] == `SCT_CODE_BYP_OFF) begin
          nxt_st.req = 1'b0;
        end else if (i_wdata[15:0] == `SCT_CODE_BYP_ON) begin
          nxt_st.req = 1'b1;
          nxt_st.unl = 1'b0;
        end else begin
          nxt_st.unl = 1'b0;
        end
      end else if (i_addr == `SCT_A_SEL) begin
        nxt_st.sel = i_wdata[15:0];
      end else if (i_addr == `SCT_A_DATA) begin
        nxt_st.refused = !dat_ok;
      end
    end
    // Register reads, data valid next cycle only
    if (i_rd) begin
      if (i_addr == `SCT_A_CTRL) begin
        nxt_st.rdata = {30'h0, st_ff.shortway, st_ff.manual};
      end else if (i_addr == `SCT_A_SEL) begin
        nxt_st.rdata = {16'h0000, st_ff.sel};
      end else if (i_addr == `SCT_A_DATA) begin
        case (st_ff.sel.tbl)
          sct_pkg::SCT_TBL_CYC: nxt_st.rdata = {24'h0, cyc_mem[st_ff.sel.dial]};
          sct_pkg::SCT_TBL_OFS: nxt_st.rdata = {24'h0, ofs_mem[{st_ff.sel.dial, st_ff.sel.ofs}]};
          sct_pkg::SCT_TBL_IVL: nxt_st.rdata = {19'h0, ivl_mem[{st_ff.sel.dial, st_ff.sel.split, st_ff.sel.ivl}]};
          sct_pkg::SCT_TBL_PLAN: nxt_st.rdata = {16'h0, plan_mem[{st_ff.sel.dial, st_ff.sel.ivl}]};
          sct_pkg::SCT_TBL_DWELL: nxt_st.rdata = {24'h0, dwl_mem[st_ff.sel.dial]};
          default: nxt_st.rdata = 32'h0000_0000;
        endcase
      end else if (i_addr == `SCT_A_STAT) begin
        nxt_st.rdata = {12'h000, st_ff.frz, st_ff.refused, st_ff.unl, st_ff.req, st_ff.plan,
                        st_ff.ivl, st_ff.ofs, st_ff.split, st_ff.dial};
      end else if (i_addr == `SCT_A_TIME) begin
        nxt_st.rdata = {2'h0, st_ff.rem, st_ff.rsec, st_ff.lsec};
      end
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
      st_ff.ivl <= `SCT_RST_IVL;
      st_ff.req <= `SCT_RST_REQ;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Table writes, only after access is granted or while the keypad check is bypassed
  always_ff @(posedge i_clk_sys) begin
    if (dat_wr) begin
      case (st_ff.sel.tbl)
        sct_pkg::SCT_TBL_CYC: cyc_mem[st_ff.sel.dial] <= i_wdata[7:0];
        sct_pkg::SCT_TBL_OFS: ofs_mem[{st_ff.sel.dial, st_ff.sel.ofs}] <= i_wdata[7:0];
        sct_pkg::SCT_TBL_IVL: ivl_mem[{st_ff.sel.dial, st_ff.sel.split, st_ff.sel.ivl}] <= i_wdata[12:0];
        sct_pkg::SCT_TBL_PLAN: plan_mem[{st_ff.sel.dial, st_ff.sel.ivl}] <= i_wdata[15:0];
        sct_pkg::SCT_TBL_DWELL: dwl_mem[st_ff.sel.dial] <= i_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Outputs
  assign o_rdata = st_ff.rdata;
  assign o_signals = st_ff.sig;
  assign o_act_dial = st_ff.dial;
  assign o_act_ofs = st_ff.ofs;
  assign o_act_ivl = st_ff.ivl;
  assign o_correcting = st_ff.frz;

  // Checks
  a_tick_on_mains: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    tick |-> (st_ff.mdiv == 3'h5) && i_mains && !st_ff.mprev)
    else $error("tick without sixth mains edge");

  a_sig_with_ivl: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !$stable(o_signals) |-> !$stable(o_act_ivl))
    else $error("signals changed inside an interval");

  a_ivl_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_act_ivl < 5'h18)
    else $error("interval index out of range");

  a_lock_refuse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_wr && i_addr == 8'h0c && st_ff.req && !st_ff.unl) |=> st_ff.refused)
    else $error("locked timing entry accepted");

  a_bypass_codes: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_wr && i_addr == 8'h04 && i_wdata[15:0] == 16'h0f0f) |=> !st_ff.req ##1 wr_ok)
    else $error("bypass code did not lift access check");

  a_dwell_limit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!st_ff.shortway && !st_ff.manual) |-> st_ff.dwc <= half_c || st_ff.ivl != 5'h00)
    else $error("dwell longer than half cycle");

  a_excluded_fixed: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (tick && st_ff.shortway && ent.excl && !step && !st_ff.frz && st_ff.rem != 14'h0)
    |=> st_ff.rem == $past(st_ff.rem) - 14'h0001)
    else $error("excluded interval time altered");

  a_manual_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (st_ff.manual && adv_req && ent.hold && st_ff.rem != 14'h0)
    |=> $stable(o_act_ivl) && $stable(o_signals))
    else $error("held interval advanced early");

  a_read_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside read slot");

  a_ref_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    cur_c != 8'h00 && $stable(cur_c) |-> st_ff.rsec < cur_c)
    else $error("reference second beyond cycle length");

  // Local second wraps at the cycle length too
  a_local_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    cur_c != 8'h00 && $stable(cur_c) |-> st_ff.lsec < cur_c)
    else $error("local second beyond cycle length");

  // Manual mode moves only on an accepted advance
  a_manual_still: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (st_ff.manual && !adv_req) |=> $stable(o_act_ivl) && $stable(o_signals))
    else $error("interval moved without advance");

  // A held second keeps the interval in place
  a_hold_no_step: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!st_ff.manual && st_ff.frz) |=> $stable(o_act_ivl))
    else $error("interval stepped while held");

  // Offset index stays inside the five stored offsets
  a_ofs_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_act_ofs < 3'h5)
    else $error("offset index out of range");

  c_cycle_wrap: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    step && nx_ivl == 5'h00);
  c_manual_step: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_ff.manual && step);
  c_dwell: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !st_ff.shortway && st_ff.frz);
  c_unlock_write: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_ff.req && dat_wr);
  c_short_way: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_ff.shortway && st_ff.frz);

endmodule

// [verification/sct_signal_cycle_timer_test.sv]
// Self-checking bench for the signal cycle timer
`timescale 1ns/1ps
`include "sct_consts.svh"

module sct_signal_cycle_timer_test;
  logic clk, rst_n, mains, wr, rd, corr, sw_mode, mon_on;
  logic [2:0] dial, ofs, plan, ofs_want, act_dial, act_ofs;
  logic [1:0] split;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [15:0] sigs;
  logic [4:0] act_ivl;
  logic [15:0] keys [5] = '{`SCT_CODE_BYP_OFF, `SCT_CODE_BYP_ON, `SCT_CODE_ACCESS, 16'h1234, `SCT_CODE_ACCESS};
  logic [1:0] kexp [5] = '{2'b00, 2'b11, 2'b01, 2'b11, 2'b01};
  int err_count, cmp_count, bad_cnt, corr_cnt, seen_corr;

  sct_tbc_model #(.MAINS_HALF(2)) tbc (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ofs_want(ofs_want), .o_mains(mains),
    .o_dial_sel(dial), .o_split_sel(split), .o_ofs_sel(ofs), .o_plan_sel(plan));
  sct_signal_cycle_timer DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_mains(mains), .i_dial_sel(dial),
    .i_split_sel(split), .i_ofs_sel(ofs), .i_plan_sel(plan), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_signals(sigs), .o_act_dial(act_dial), .o_act_ofs(act_ofs),
    .o_act_ivl(act_ivl), .o_correcting(corr));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Register port cycles, one idle cycle after each strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask

  function automatic logic [31:0] sel(input logic [2:0] t, input logic [4:0] i, input logic [2:0] o);
    return {16'h0, t, i, o, 5'h0};
  endfunction

  // Interval entries: 1 s unit on 1, hold on 2, excluded on 5; 60 ticks in all
  function automatic logic [31:0] ient(input int i);
    case (i)
      1: return 32'h401;
      2: return 32'h804;
      3: return 32'h4;
      5: return 32'h1002;
      default: return 32'h2;
    endcase
  endfunction

  function automatic logic [31:0] pat(input int i);
    return 32'ha500 | 32'(i);
  endfunction

  task automatic put(input logic [2:0] t, input logic [4:0] i, input logic [2:0] o, input logic [31:0] v);
    wr_reg(`SCT_A_SEL, sel(t, i, o));
    wr_reg(`SCT_A_DATA, v);
  endtask

  task automatic wait_ivl(input int i);
    int w;
    w = 0;
    while (act_ivl !== 5'(i) && w < 4000) begin
      @(negedge clk);
      w++;
    end
    if (w == 4000) bad_cnt++;
  endtask

  task automatic cycles(input int c);
    for (int k = 0; k < c; k++) begin
      wait_ivl(1);
      wait_ivl(0);
    end
  endtask

  // Interval length in clocks, outputs steady throughout
  task automatic meas(input int i);
    int n;
    int t;
    logic [31:0] v;
    wait_ivl(i);
    chk("interval signals", pat(i), {16'h0, sigs});
    n = 0;
    v = ient(i);
    t = v[10] ? v[9:0] * 10 : v[9:0];
    while (act_ivl === 5'(i) && n < 4000) begin
      if ({16'h0, sigs} !== pat(i)) bad_cnt++;
      @(negedge clk);
      n++;
    end
    chk("interval length", 32'h1, {31'h0, n >= t * 24 - 24 && n <= t * 24 + 24});
  endtask

  // Where and how long local timing is held
  always @(negedge clk) begin
    if (mon_on && act_ivl === 5'h1) corr_cnt = 0;
    if (mon_on && corr === 1'b1) begin
      seen_corr++;
      corr_cnt++;
      if (!sw_mode && (act_ivl !== 5'h0 || corr_cnt > 264)) bad_cnt++;
      if (sw_mode && act_ivl === 5'h5) bad_cnt++;
    end
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    ofs_want = 3'h0;
    sw_mode = 1'b0;
    mon_on = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Flags after reset, idle read data, unmapped place
    rd_reg(`SCT_A_STAT, d);
    chk("stat flags", 32'h1, {29'h0, d[18:16]});
    #1 chk("idle rdata", 32'h0, rdata);
    rd_reg(`SCT_A_CTRL, d);
    chk("ctrl reset", 32'h0, d);
    rd_reg(8'h1c, d);
    chk("unmapped read", 32'h0, d);
    // Entry while locked, then every keypad code
    put(3'h0, 5'h0, 3'h0, 32'h9);
    rd_reg(`SCT_A_STAT, d);
    chk("locked refused", 32'h1, {31'h0, d[18]});
    for (int k = 0; k < 5; k++) begin
      wr_reg(`SCT_A_KEY, {16'h0, keys[k]});
      wr_reg(`SCT_A_DATA, 32'h9);
      rd_reg(`SCT_A_STAT, d);
      chk("key flags", {30'h0, kexp[k]}, {30'h0, d[18], d[16]});
    end
    // Indexes beyond the tables
    for (int k = 0; k < 3; k++) begin
      put(k == 0 ? 3'h2 : k == 1 ? 3'h1 : 3'h5, k == 0 ? 5'h18 : 5'h0, k == 1 ? 3'h5 : 3'h0, 32'h2);
      rd_reg(`SCT_A_STAT, d);
      chk("bad index refused", 32'h1, {31'h0, d[18]});
    end
    // Dial 0: 6 s cycle, 1 s dwell, offsets 0, 2 and 3 s, intervals and plan 0
    put(3'h0, 5'h0, 3'h0, 32'h6);
    put(3'h4, 5'h0, 3'h0, 32'h1);
    for (int k = 0; k < 3; k++) put(3'h1, 5'h0, 3'(k), k == 0 ? 32'h0 : 32'(k + 1));
    for (int k = 0; k < 24; k++) begin
      put(3'h2, 5'(k), 3'h0, ient(k));
      put(3'h3, 5'(k), 3'h0, pat(k));
    end
    rd_reg(`SCT_A_DATA, d);
    chk("plan readback", pat(23), d);
    wr_reg(`SCT_A_SEL, sel(3'h2, 5'h2, 3'h0));
    rd_reg(`SCT_A_DATA, d);
    chk("interval readback", 32'h804, d);
    // Second reset keeps the tables; manual stepping
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    mon_on = 1'b1;
    @(posedge clk);
    wr_reg(`SCT_A_CTRL, 32'h1);
    for (int k = 0; k < 3; k++) begin
      #1 chk("manual interval", 32'(k), {27'h0, act_ivl});
      chk("manual signals", pat(k), {16'h0, sigs});
      wr_reg(`SCT_A_ADV, 32'h0);
    end
    #1 chk("hold refuses advance", 32'h2, {27'h0, act_ivl});
    repeat (120) @(posedge clk);
    wr_reg(`SCT_A_ADV, 32'h0);
    #1 chk("advance after timeout", 32'h3, {27'h0, act_ivl});
    rd_reg(`SCT_A_STAT, d);
    chk("stat interval", 32'h3, {27'h0, d[12:8]});
    // Automatic timing, then dwell correction settling
    wr_reg(`SCT_A_CTRL, 32'h0);
    for (int k = 1; k < 4; k++) meas(k);
    chk("active dial", 32'h0, {29'h0, act_dial});
    cycles(6);
    seen_corr = 0;
    cycles(1);
    chk("settled", 32'h0, 32'(seen_corr));
    ofs_want <= 3'h1;
    cycles(3);
    chk("active offset", 32'h1, {29'h0, act_ofs});
    chk("dwell seen", 32'h1, {31'h0, seen_corr != 0});
    // Short-way correction
    wr_reg(`SCT_A_CTRL, 32'h2);
    sw_mode = 1'b1;
    rd_reg(`SCT_A_CTRL, d);
    chk("ctrl readback", 32'h2, d);
    ofs_want <= 3'h2;
    seen_corr = 0;
    cycles(3);
    chk("short way seen", 32'h1, {31'h0, seen_corr != 0});
    chk("correction placement", 32'h0, 32'(bad_cnt));
    stop_test();
  end
endmodule

// [verification/sct_tbc_model.sv]
// Time-base coordinator and mains reference model facing the cycle timer
`timescale 1ns/1ps

module sct_tbc_model #(
  parameter int MAINS_HALF = 2
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Offset wanted by the bench
  input wire logic [2:0] i_ofs_want,
  // Mains and select lines
  output logic o_mains,
  output logic [2:0] o_dial_sel,
  output logic [1:0] o_split_sel,
  output logic [2:0] o_ofs_sel,
  output logic [2:0] o_plan_sel
);
  int half_cnt;

  // Scaled mains square wave, kept short so a tick is 24 clocks
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      half_cnt <= 0;
      o_mains <= 1'b0;
    end else if (half_cnt == MAINS_HALF - 1) begin
      half_cnt <= 0;
      o_mains <= ~o_mains;
    end else begin
      half_cnt <= half_cnt + 1;
    end
  end

  // Offset select held as a level, changed only after a clock edge
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ofs_sel <= 3'h0;
    end else begin
      o_ofs_sel <= i_ofs_want;
    end
  end

  // Dial, split and plan lines stay on their first choice
  assign o_dial_sel = 3'h0;
  assign o_split_sel = 2'h0;
  assign o_plan_sel = 3'h0;
endmodule
